/* hw/hpr_pkg.sv */
package hpr_pkg;
  // Device register offsets on the host bus
  localparam logic [4:0] OFF_CMD    = 5'h00;
  localparam logic [4:0] OFF_RECEIVE_BOUNDARY_POINTER   = 5'h03;
  localparam logic [4:0] OFF_ISR    = 5'h07;  // Page 1: current page
  localparam logic [4:0] OFF_REMOTE_START_ADDR_LOW  = 5'h08;
  localparam logic [4:0] OFF_REMOTE_START_ADDR_HIGH  = 5'h09;
  localparam logic [4:0] OFF_REMOTE_BYTE_COUNT_LOW  = 5'h0A;
  localparam logic [4:0] OFF_REMOTE_BYTE_COUNT_HIGH  = 5'h0B;
  localparam logic [4:0] OFF_RD0D   = 5'h0D;
  localparam logic [4:0] OFF_CRC    = 5'h0E;
  localparam logic [4:0] OFF_MISS   = 5'h0F;
  localparam logic [4:0] OFF_DATA   = 5'h10;
  localparam logic [4:0] OFF_SPARE  = 5'h1C;
  localparam logic [4:0] OFF_RESET  = 5'h1F;

  // Command fields and interrupt flags
  localparam int         CMD_DMA_LSB = 3;
  localparam int         CMD_PAGE    = 6;
  localparam logic [2:0] DMA_READ    = 3'h1;
  localparam logic [2:0] DMA_WRITE   = 3'h2;
  localparam logic [2:0] DMA_ABORT   = 3'h4;
  localparam int         ISR_RDC     = 6;
  localparam int         ISR_RST     = 7;
  localparam logic [7:0] RST_CMD     = 8'h21;

  // Station-address image
  localparam logic [4:0] IMG_END    = 5'h1F;
  localparam logic [4:0] IMG_MODE_A = 5'h1C;
  localparam logic [4:0] IMG_MODE_B = 5'h1E;
  localparam logic [7:0] MODE_16    = 8'h57;
  localparam logic [7:0] MODE_8     = 8'h42;
  localparam int         EE_WORDS   = 16;

  // Timing: the system clock is the local bus clock
  localparam int CLK_NS       = 100;
  localparam int BUSY_NS      = 250;  // 2.5 local bus clocks
  localparam int BUSY_CYC     = (BUSY_NS + CLK_NS - 1) / CLK_NS;
  localparam int PREFETCH_NS  = 700;  // 7 local bus clocks
  localparam int PREFETCH_CYC = (PREFETCH_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOST_CYC     = 3;

  // Host controller registers
  localparam logic [7:0] H_TARGET = 8'h00;
  localparam logic [7:0] H_WRITE  = 8'h01;
  localparam logic [7:0] H_READ   = 8'h02;
  localparam logic [7:0] H_RESULT = 8'h03;
  localparam logic [7:0] H_STATUS = 8'h04;
  localparam logic [7:0] H_CTRL   = 8'h05;
  localparam int         TGT_WORD = 8;

  // Accesses after which the device stays busy
  function automatic logic busy_access(input logic       wr,
                                       input logic [4:0] a);
    if (wr) begin
      return a == OFF_CMD || a == OFF_RECEIVE_BOUNDARY_POINTER || a == OFF_ISR
          || (a >= OFF_REMOTE_START_ADDR_LOW && a <= OFF_REMOTE_BYTE_COUNT_HIGH) || a == OFF_DATA;
    end
    return (a >= OFF_RD0D && a <= OFF_MISS) || a == OFF_DATA
        || a == OFF_RESET;
  endfunction : busy_access
endpackage : hpr_pkg

/* hw/hpr_bus_if.sv */
`timescale 1ns/1ns
interface hpr_bus_if;
  logic        rd;
  logic        wr;
  logic [4:0]  addr;
  logic        word;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        rdy;

  modport dev_mp  (input rd, wr, addr, word, wdata, output rdata, rdy);
  modport host_mp (output rd, wr, addr, word, wdata, input rdata, rdy);
endinterface : hpr_bus_if

/* hw/hpr_dev_end.sv */
`timescale 1ns/1ns
module hpr_dev_end #(
  parameter int BUF_AW = 10
) (
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  // Host bus
  hpr_bus_if.dev_mp        bus,
  // Serial EEPROM word reader
  output logic [3:0]       ee_addr_o,
  output logic             ee_rd_o,
  input  wire logic [15:0] ee_word_i,
  input  wire logic        ee_present_i,
  input  wire logic        eeprom_serial_out_i,
  // Straps and events
  input  wire logic        word_bus_i,
  input  wire logic        crc_err_i,
  input  wire logic        missed_i,
  output logic             load_done_o
);

  logic [15:0] mem [2**BUF_AW];
  logic [15:0] prom [hpr_pkg::EE_WORDS];
  logic [7:0]  cmd, receive_boundary_pointer, interrupt_status_flags, current_page_pointer, crc_cnt, miss_cnt;
  logic [15:0] rsar, rbcr;
  logic [1:0]  busy_cnt;
  logic [2:0]  pf_cnt;
  logic [2:0]  pin_sync;
  logic        pin_level, cap, loading;
  logic [3:0]  cap_addr;
  logic [4:0]  ld_cnt;

  logic [7:0]  next_cmd, next_receive_boundary_pointer, next_isr, next_cpr;
  logic [7:0]  next_crc, next_miss;
  logic [15:0] next_rsar, next_rbcr, next_rdata, src, img;
  logic [1:0]  next_busy;
  logic [2:0]  next_pf;
  logic [4:0]  next_ld;
  logic        rd_ok, wr_ok, page1, dp_ok, dp_rd, dp_wr, next_loading;
  logic [7:0]  iomode;
  logic [15:0] step;

  ////////////////////////////////////////////////////////////////////////
  // Strap pin filter and EEPROM load
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      // Match the filtered level so release gives no false strap edge
      pin_sync  <= 3'h7;
      pin_level <= 1'b1;
    end else begin
      pin_sync <= {pin_sync[1:0], eeprom_serial_out_i};
      if (pin_sync[2] == pin_sync[1]) begin
        pin_level <= pin_sync[2];
      end
    end
  end

  // Pulled low means a 16-bit host, floating means 8-bit
  assign iomode = pin_level ? hpr_pkg::MODE_8 : hpr_pkg::MODE_16;

  always_comb begin
    next_ld      = ld_cnt;
    next_loading = loading;
    if (loading && !ee_present_i) begin
      next_loading = 1'b0;
    end else if (loading && ld_cnt != 5'h1F) begin
      next_ld = ld_cnt + 5'h01;
    end
    if (cap && cap_addr == 4'hF) begin
      next_loading = 1'b0;
    end
  end

  // One 16-bit word per read, two cycles per word
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ld_cnt      <= 5'h00;
      loading     <= 1'b1;
      ee_rd_o     <= 1'b0;
      ee_addr_o   <= 4'h0;
      cap         <= 1'b0;
      cap_addr    <= 4'h0;
      load_done_o <= 1'b0;
    end else begin
      ld_cnt      <= next_ld;
      loading     <= next_loading;
      ee_rd_o     <= loading && ee_present_i && !ld_cnt[0];
      ee_addr_o   <= ld_cnt[4:1];
      cap         <= ee_rd_o;
      cap_addr    <= ee_addr_o;
      load_done_o <= !next_loading;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (cap) begin
      prom[cap_addr] <= ee_word_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register access and remote DMA
  always_comb begin
    img = prom[rsar[4:1]];
    if (!ee_present_i && (rsar[4:0] == hpr_pkg::IMG_MODE_A
                       || rsar[4:0] == hpr_pkg::IMG_MODE_B)) begin
      img = {8'h00, iomode};
    end
  end

  assign src = (rsar <= {11'h000, hpr_pkg::IMG_END}) ? img
             : mem[rsar[BUF_AW:1]];

  always_comb begin
    rd_ok      = bus.rd && !loading && busy_cnt == 2'h0;
    wr_ok      = bus.wr && !loading && busy_cnt == 2'h0;
    page1      = cmd[hpr_pkg::CMD_PAGE];
    dp_ok      = !word_bus_i || bus.word;
    step       = bus.word ? 16'h0002 : 16'h0001;
    dp_rd      = rd_ok && bus.addr == hpr_pkg::OFF_DATA && dp_ok
              && cmd[5:3] == hpr_pkg::DMA_READ && pf_cnt == 3'h0
              && rbcr != 16'h0000;
    dp_wr      = wr_ok && bus.addr == hpr_pkg::OFF_DATA && dp_ok
              && cmd[5:3] == hpr_pkg::DMA_WRITE && rbcr != 16'h0000;
    next_cmd   = cmd;
    next_receive_boundary_pointer  = receive_boundary_pointer;
    next_isr   = interrupt_status_flags;
    next_cpr   = current_page_pointer;
    next_rsar  = rsar;
    next_rbcr  = rbcr;
    next_rdata = 16'h0000;
    next_pf    = (pf_cnt != 3'h0) ? pf_cnt - 3'h1 : 3'h0;
    next_busy  = (busy_cnt != 2'h0) ? busy_cnt - 2'h1 : 2'h0;
    next_crc   = crc_cnt;
    next_miss  = miss_cnt;
    if ((rd_ok || wr_ok) && hpr_pkg::busy_access(bus.wr, bus.addr)) begin
      next_busy = 2'(hpr_pkg::BUSY_CYC);
    end
    if (wr_ok) begin
      case (bus.addr)
        hpr_pkg::OFF_CMD: begin
          next_cmd = bus.wdata[7:0];
          if (bus.wdata[5:3] == hpr_pkg::DMA_READ) begin
            next_pf = 3'(hpr_pkg::PREFETCH_CYC);
          end
        end
        hpr_pkg::OFF_RECEIVE_BOUNDARY_POINTER: next_receive_boundary_pointer = bus.wdata[7:0];
        hpr_pkg::OFF_ISR: begin
          if (page1) begin
            next_cpr = bus.wdata[7:0];
          end else begin
            next_isr = interrupt_status_flags & ~bus.wdata[7:0];
          end
        end
        hpr_pkg::OFF_REMOTE_START_ADDR_LOW: next_rsar[7:0]  = bus.wdata[7:0];
        hpr_pkg::OFF_REMOTE_START_ADDR_HIGH: next_rsar[15:8] = bus.wdata[7:0];
        hpr_pkg::OFF_REMOTE_BYTE_COUNT_LOW: next_rbcr[7:0]  = bus.wdata[7:0];
        hpr_pkg::OFF_REMOTE_BYTE_COUNT_HIGH: next_rbcr[15:8] = bus.wdata[7:0];
        default: ;
      endcase
    end
    if (rd_ok) begin
      case (bus.addr)
        hpr_pkg::OFF_CMD:  next_rdata = {8'h00, cmd};
        hpr_pkg::OFF_RECEIVE_BOUNDARY_POINTER: next_rdata = {8'h00, receive_boundary_pointer};
        hpr_pkg::OFF_ISR:  next_rdata = {8'h00, page1 ? current_page_pointer : interrupt_status_flags};
        hpr_pkg::OFF_CRC:  next_rdata = {8'h00, crc_cnt};
        hpr_pkg::OFF_MISS: next_rdata = {8'h00, miss_cnt};
        hpr_pkg::OFF_DATA: begin
          if (dp_rd) begin
            next_rdata = bus.word ? src
                       : {8'h00, rsar[0] ? src[15:8] : src[7:0]};
          end
        end
        hpr_pkg::OFF_RESET: begin
          next_isr[hpr_pkg::ISR_RST] = 1'b1;
          next_cmd[5:3]              = hpr_pkg::DMA_ABORT;
        end
        default: ;
      endcase
      // Tallies clear on read; an event in the same cycle still counts
      if (bus.addr == hpr_pkg::OFF_CRC) begin
        next_crc = 8'h00;
      end
      if (bus.addr == hpr_pkg::OFF_MISS) begin
        next_miss = 8'h00;
      end
    end
    if (crc_err_i && next_crc != 8'hFF) begin
      next_crc = next_crc + 8'h01;
    end
    if (missed_i && next_miss != 8'hFF) begin
      next_miss = next_miss + 8'h01;
    end
    if (dp_rd || dp_wr) begin
      next_rsar = rsar + step;
      next_rbcr = (rbcr <= step) ? 16'h0000 : rbcr - step;
      if (rbcr <= step) begin
        next_isr[hpr_pkg::ISR_RDC] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (dp_wr) begin
      if (bus.word || !rsar[0]) begin
        mem[rsar[BUF_AW:1]][7:0] <= bus.word ? bus.wdata[7:0]
                                             : bus.wdata[7:0];
      end
      if (bus.word) begin
        mem[rsar[BUF_AW:1]][15:8] <= bus.wdata[15:8];
      end else if (rsar[0]) begin
        mem[rsar[BUF_AW:1]][15:8] <= bus.wdata[7:0];
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmd       <= hpr_pkg::RST_CMD;
      receive_boundary_pointer      <= 8'h00;
      interrupt_status_flags       <= 8'h00;
      current_page_pointer       <= 8'h00;
      rsar      <= 16'h0000;
      rbcr      <= 16'h0000;
      crc_cnt   <= 8'h00;
      miss_cnt  <= 8'h00;
      busy_cnt  <= 2'h0;
      pf_cnt    <= 3'h0;
      bus.rdata <= 16'h0000;
      bus.rdy   <= 1'b0;
    end else begin
      cmd       <= next_cmd;
      receive_boundary_pointer      <= next_receive_boundary_pointer;
      interrupt_status_flags       <= next_isr;
      current_page_pointer       <= next_cpr;
      rsar      <= next_rsar;
      rbcr      <= next_rbcr;
      crc_cnt   <= next_crc;
      miss_cnt  <= next_miss;
      busy_cnt  <= next_busy;
      pf_cnt    <= next_pf;
      bus.rdata <= next_rdata;
      bus.rdy   <= next_busy == 2'h0 && !next_loading;
    end
  end

endmodule : hpr_dev_end

/* hw/hpr_host_end.sv */
`timescale 1ns/1ns
module hpr_host_end #(
  parameter int         HOST_CYCLE  = hpr_pkg::HOST_CYC,
  parameter int         DUMMY_READS = 1,
  parameter logic       WORD_BUS    = 1'b1
) (
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  // Host bus
  hpr_bus_if.host_mp       bus,
  // Software port
  input  wire logic [7:0]  cfg_addr_i,
  input  wire logic [15:0] cfg_wdata_i,
  input  wire logic        cfg_wr_i,
  input  wire logic        cfg_rd_i,
  output logic [15:0]      cfg_rdata_o,
  output logic             busy_o
);

  typedef enum logic [1:0] {
    HS_IDLE  = 2'b00,
    HS_GAP   = 2'b01,
    HS_DUMMY = 2'b11,
    HS_RDYW  = 2'b10
  } hpr_state_e;

  localparam logic [1:0] GAP_LOAD = 2'(HOST_CYCLE - 2);
  localparam logic       NEED_DUMMY = HOST_CYCLE <= hpr_pkg::BUSY_CYC;

  hpr_state_e  state, next_state;
  logic [1:0]  gap_cnt, next_gap;
  logic [2:0]  guard, next_guard;
  logic [3:0]  dum_cnt, next_dum;
  logic [4:0]  tgt_addr, next_tgt_addr;
  logic        tgt_word, next_tgt_word;
  logic        pend, next_pend, pend_wr, next_pend_wr;
  logic [15:0] pend_data, next_pend_data;
  logic        last_rd, next_last_rd, last_aff, next_last_aff;
  logic        use_rdy, next_use_rdy, refused, next_refused;
  logic [15:0] result, next_result, next_cfg_rdata;
  logic        next_rd, next_wr, next_word;
  logic [4:0]  next_addr;
  logic [15:0] next_wdata;
  logic        launch, can_go, is_dp;

  ////////////////////////////////////////////////////////////////////////
  // Software registers
  always_comb begin
    next_tgt_addr  = tgt_addr;
    next_tgt_word  = tgt_word;
    next_use_rdy   = use_rdy;
    next_pend      = pend;
    next_pend_wr   = pend_wr;
    next_pend_data = pend_data;
    next_refused   = refused;
    next_cfg_rdata = 16'h0000;
    launch         = cfg_wr_i && (cfg_addr_i == hpr_pkg::H_WRITE
                               || cfg_addr_i == hpr_pkg::H_READ);
    if (cfg_rd_i) begin
      case (cfg_addr_i)
        hpr_pkg::H_TARGET: begin
          next_cfg_rdata = {7'h00, tgt_word, 3'h0, tgt_addr};
        end
        hpr_pkg::H_RESULT: next_cfg_rdata = result;
        hpr_pkg::H_STATUS: begin
          next_cfg_rdata = {14'h0000, refused, busy_o};
          next_refused   = 1'b0;
        end
        hpr_pkg::H_CTRL: next_cfg_rdata = {15'h0000, use_rdy};
        default: ;
      endcase
    end
    if (cfg_wr_i && cfg_addr_i == hpr_pkg::H_TARGET) begin
      next_tgt_addr = cfg_wdata_i[4:0];
      next_tgt_word = cfg_wdata_i[hpr_pkg::TGT_WORD];
    end
    if (cfg_wr_i && cfg_addr_i == hpr_pkg::H_CTRL) begin
      next_use_rdy = cfg_wdata_i[0];
    end
    // An order while one is pending or on the bus is dropped and flagged
    if (launch && (pend || state != HS_IDLE)) begin
      next_refused = 1'b1;
    end else if (launch) begin
      next_pend      = 1'b1;
      next_pend_wr   = cfg_addr_i == hpr_pkg::H_WRITE;
      next_pend_data = cfg_wdata_i;
    end
    if (state == HS_IDLE && pend && can_go) begin
      next_pend = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus cycle pacing
  assign is_dp  = tgt_addr == hpr_pkg::OFF_DATA;
  // A data read waits out the prefetch after a read command
  assign can_go = pend_wr || !is_dp || guard == 3'h0;

  always_comb begin
    next_state    = state;
    next_gap      = gap_cnt;
    next_dum      = dum_cnt;
    next_last_rd  = last_rd;
    next_last_aff = last_aff;
    next_result   = result;
    next_guard    = (guard != 3'h0) ? guard - 3'h1 : 3'h0;
    next_rd       = 1'b0;
    next_wr       = 1'b0;
    next_addr     = bus.addr;
    next_word     = bus.word;
    next_wdata    = bus.wdata;
    case (state)
      HS_IDLE: begin
        if (pend && can_go) begin
          next_rd       = !pend_wr;
          next_wr       = pend_wr;
          next_addr     = tgt_addr;
          next_word     = tgt_word || (WORD_BUS && is_dp);
          next_wdata    = pend_data;
          next_last_rd  = !pend_wr;
          next_last_aff = hpr_pkg::busy_access(pend_wr, tgt_addr);
          next_gap      = GAP_LOAD;
          next_state    = HS_GAP;
          if (pend_wr && tgt_addr == hpr_pkg::OFF_CMD
              && pend_data[5:3] == hpr_pkg::DMA_READ) begin
            next_guard = 3'(hpr_pkg::PREFETCH_CYC);
          end
        end
      end
      HS_GAP: begin
        if (gap_cnt != 2'h0) begin
          next_gap = gap_cnt - 2'h1;
        end else begin
          if (last_rd && last_aff) begin
            next_result = bus.rdata;
          end else if (last_rd && bus.addr != hpr_pkg::OFF_SPARE) begin
            next_result = bus.rdata;
          end
          next_last_aff = 1'b0;
          if (last_aff && use_rdy) begin
            next_state = HS_RDYW;
          end else if (last_aff && NEED_DUMMY) begin
            next_dum   = 4'(DUMMY_READS);
            next_state = HS_DUMMY;
          end else if (dum_cnt != 4'h0) begin
            next_state = HS_DUMMY;
          end else begin
            next_state = HS_IDLE;
          end
        end
      end
      HS_DUMMY: begin
        if (dum_cnt == 4'h0) begin
          next_state = HS_IDLE;
        end else begin
          next_rd      = 1'b1;
          next_addr    = hpr_pkg::OFF_SPARE;
          next_word    = 1'b0;
          next_last_rd = 1'b0;
          next_dum     = dum_cnt - 4'h1;
          next_gap     = GAP_LOAD;
          next_state   = HS_GAP;
        end
      end
      HS_RDYW: begin
        if (bus.rdy) begin
          next_state = HS_IDLE;
        end
      end
      default: next_state = HS_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state       <= HS_IDLE;
      gap_cnt     <= 2'h0;
      guard       <= 3'h0;
      dum_cnt     <= 4'h0;
      tgt_addr    <= 5'h00;
      tgt_word    <= 1'b0;
      pend        <= 1'b0;
      pend_wr     <= 1'b0;
      pend_data   <= 16'h0000;
      last_rd     <= 1'b0;
      last_aff    <= 1'b0;
      use_rdy     <= 1'b0;
      refused     <= 1'b0;
      result      <= 16'h0000;
      cfg_rdata_o <= 16'h0000;
      busy_o      <= 1'b0;
      bus.rd      <= 1'b0;
      bus.wr      <= 1'b0;
      bus.addr    <= 5'h00;
      bus.word    <= 1'b0;
      bus.wdata   <= 16'h0000;
    end else begin
      state       <= next_state;
      gap_cnt     <= next_gap;
      guard       <= next_guard;
      dum_cnt     <= next_dum;
      tgt_addr    <= next_tgt_addr;
      tgt_word    <= next_tgt_word;
      pend        <= next_pend;
      pend_wr     <= next_pend_wr;
      pend_data   <= next_pend_data;
      last_rd     <= next_last_rd;
      last_aff    <= next_last_aff;
      use_rdy     <= next_use_rdy;
      refused     <= next_refused;
      result      <= next_result;
      cfg_rdata_o <= next_cfg_rdata;
      busy_o      <= next_pend || next_state != HS_IDLE;
      bus.rd      <= next_rd;
      bus.wr      <= next_wr;
      bus.addr    <= next_addr;
      bus.word    <= next_word;
      bus.wdata   <= next_wdata;
    end
  end

endmodule : hpr_host_end

/* testbench/hpr_bus_properties.sv */
`timescale 1ns/1ns
module hpr_bus_properties (
  // Clock and reset
  input wire logic        clk_sys_i,
  input wire logic        rst_n_i,
  // Bus between the two ends
  input wire logic        rd,
  input wire logic        wr,
  input wire logic [4:0]  addr,
  input wire logic        word,
  input wire logic [15:0] wdata,
  input wire logic [15:0] rdata,
  input wire logic        rdy
);
  logic busy_acc;

  // Accesses that leave the device busy; page bit is not looked at
  assign busy_acc = wr ? (addr == 5'h00 || addr == 5'h03 || addr == 5'h07
      || (addr >= 5'h08 && addr <= 5'h0B) || addr == 5'h10)
    : rd && ((addr >= 5'h0D && addr <= 5'h0F) || addr == 5'h10
      || addr == 5'h1F);

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_hold;
    !rdy [*3];
  endsequence
  sequence s_quiet;
    !(rd || wr) [*2];
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  AST_BUSY_RDY: assert property (rdy && busy_acc |=> s_hold)
    else $error("ready did not drop after a busy access");
  AST_RECEIVE_BOUNDARY_POINTER_BACK: assert property (rdy && wr && addr == 5'h03 |=> s_hold ##1 rdy)
    else $error("ready not back three cycles after a boundary write");
  AST_RDATA_PULSE: assert property (!rd |=> rdata == 16'h0000)
    else $error("read data shown without a read");
  AST_SPARE_ZERO: assert property (rd && addr == 5'h1C |=> rdata == 16'h0000)
    else $error("spare slot read returned data");
  AST_HOST_WORD: assert property ((rd || wr) && addr == 5'h10 |-> word)
    else $error("data port access was not a word");
  AST_HOST_GAP: assert property ((rd || wr) && busy_acc |=> s_quiet)
    else $error("host accessed inside the busy time");
  AST_HOST_DUMMY: assert property ((rd || wr) && busy_acc
      |-> ##3 (rd && addr == 5'h1C))
    else $error("host skipped the dummy read");
  AST_HOST_PREFETCH: assert property (wr && addr == 5'h00 && wdata[5:3] == 3'h1
      |=> !(rd && addr == 5'h10) [*6])
    else $error("data port read too soon after the read command");
endmodule : hpr_bus_properties

/* testbench/host_port_remote_read_pacing_bench.sv */
`timescale 1ns/1ns
module host_port_remote_read_pacing_bench;
  logic        clk_sys, rst_n, rst2_n, strap, ld1, ld2, cfg_wr, cfg_rd, busy;
  logic [1:0]  ev, ev1;
  logic [3:0]  ea1, ea2;
  logic [7:0]  cfg_addr;
  logic [15:0] cfg_wdata, cfg_rdata, q, v;
  int          num_errors, n_checks, seed, n;

  function automatic logic [15:0] ee_fn(input logic [3:0] a);
    return {4'hA, a, ~a, 4'h3};
  endfunction : ee_fn

  hpr_bus_if b1 ();
  hpr_bus_if b2 ();
  hpr_dev_end i_hpr_dev_end (.clk_sys_i(clk_sys), .rst_n_i(rst_n), .bus(b1),
    .ee_addr_o(ea1), .ee_rd_o(), .ee_word_i(ee_fn(ea1)), .ee_present_i(1'b1),
    .eeprom_serial_out_i(1'b0), .word_bus_i(1'b1), .crc_err_i(ev1[0]),
    .missed_i(ev1[1]), .load_done_o(ld1));
  // Second device faces the bench directly, so rule breaking is possible
  hpr_dev_end i_hpr_dev_end_b (.clk_sys_i(clk_sys), .rst_n_i(rst2_n),
    .bus(b2), .ee_addr_o(ea2), .ee_rd_o(), .ee_word_i(ee_fn(ea2)),
    .ee_present_i(1'b0), .eeprom_serial_out_i(strap), .word_bus_i(1'b1),
    .crc_err_i(ev[0]), .missed_i(ev[1]), .load_done_o(ld2));
  hpr_host_end i_hpr_host_end (.clk_sys_i(clk_sys), .rst_n_i(rst_n),
    .bus(b1), .cfg_addr_i(cfg_addr), .cfg_wdata_i(cfg_wdata),
    .cfg_wr_i(cfg_wr), .cfg_rd_i(cfg_rd), .cfg_rdata_o(cfg_rdata),
    .busy_o(busy));
  hpr_bus_properties i_hpr_bus_properties (.clk_sys_i(clk_sys),
    .rst_n_i(rst_n), .rd(b1.rd), .wr(b1.wr), .addr(b1.addr),
    .word(b1.word), .wdata(b1.wdata), .rdata(b1.rdata), .rdy(b1.rdy));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) ev1 <= 2'($random(seed));

  task automatic chk(input string nm, input logic [15:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic end_of_test;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test

  task automatic cw(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    cfg_wr <= 1'b1;
    cfg_addr <= a;
    cfg_wdata <= d;
    @(posedge clk_sys);
    cfg_wr <= 1'b0;
  endtask : cw

  task automatic cr(input logic [7:0] a);
    @(posedge clk_sys);
    cfg_rd <= 1'b1;
    cfg_addr <= a;
    @(posedge clk_sys);
    cfg_rd <= 1'b0;
    #1 q = cfg_rdata;
  endtask : cr

  // Busy rises one cycle after the order; poll off the edge
  task automatic wbusy;
    @(posedge clk_sys);
    #1;
    for (int i = 0; i < 60 && busy !== 1'b0; i++) begin
      @(posedge clk_sys);
      #1;
    end
  endtask : wbusy

  task automatic hop(input logic w, input logic [4:0] a, input logic [15:0] d);
    cw(8'h00, {7'h00, a == 5'h10, 3'h0, a});
    cw(w ? 8'h01 : 8'h02, d);
    wbusy();
    if (!w) cr(8'h03);
  endtask : hop

  // Direct access to the second device; gap 2 keeps the busy spacing
  task automatic acc2(input logic w, input logic [4:0] a, input logic [15:0] d,
                      input int gap);
    @(posedge clk_sys);
    b2.wr <= w;
    b2.rd <= !w;
    b2.addr <= a;
    b2.word <= a == 5'h10;
    b2.wdata <= d;
    @(posedge clk_sys);
    b2.wr <= 1'b0;
    b2.rd <= 1'b0;
    #1 q = b2.rdata;
    repeat (gap) @(posedge clk_sys);
  endtask : acc2

  initial begin
    repeat (30000) @(posedge clk_sys);
    num_errors++;
    end_of_test();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'h0000_6e6a;
    {rst_n, rst2_n, strap, ev, cfg_wr, cfg_rd} = '0;
    {cfg_addr, cfg_wdata} = '0;
    {b2.rd, b2.wr, b2.addr, b2.word, b2.wdata} = '0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (int i = 0; i < 100 && ld1 !== 1'b1; i++) @(posedge clk_sys);
    // Command before counts, then stream the whole image
    hop(1, 5'h09, 16'h0000);
    hop(1, 5'h08, 16'h0000);
    hop(1, 5'h00, 16'h000A);
    hop(1, 5'h0B, 16'h0000);
    hop(1, 5'h0A, 16'h0020);
    for (int k = 0; k < 16; k++) begin
      hop(0, 5'h10, 16'h0000);
      chk("image word", q, ee_fn(4'(k)));
    end
    hop(0, 5'h07, 16'h0000);
    chk("dma done flag", q & 16'h0040, 16'h0040);
    hop(1, 5'h07, 16'h0040);
    hop(0, 5'h07, 16'h0000);
    chk("dma done cleared", q & 16'h0040, 16'h0000);
    hop(0, 5'h1F, 16'h0000);
    hop(0, 5'h07, 16'h0000);
    chk("reset flag", q & 16'h0080, 16'h0080);
    repeat (4) begin
      v = 16'($random(seed));
      hop(1, 5'h03, v);
      hop(0, 5'h03, 16'h0000);
      chk("boundary", q, {8'h00, v[7:0]});
    end
    // Second order lands while the first is paced and must be dropped
    cw(8'h00, 16'h0003);
    cw(8'h01, 16'h0005);
    cw(8'h01, 16'h0006);
    wbusy();
    cr(8'h04);
    chk("refused flag", q & 16'h0002, 16'h0002);
    cr(8'h04);
    chk("refused cleared", q & 16'h0002, 16'h0000);
    cr(8'h00);
    chk("target kept", q, 16'h0003);
    hop(0, 5'h03, 16'h0000);
    chk("boundary kept", q, 16'h0005);
    for (int s = 0; s < 2; s++) begin
      rst2_n <= 1'b0;
      strap <= 1'(s);
      repeat (4) @(posedge clk_sys);
      rst2_n <= 1'b1;
      for (int i = 0; i < 100 && ld2 !== 1'b1; i++) @(posedge clk_sys);
      repeat (4) @(posedge clk_sys);
      acc2(1, 5'h09, 16'h0000, 2);
      acc2(1, 5'h08, 16'h001C, 2);
      acc2(1, 5'h00, 16'h000A, 2);
      acc2(1, 5'h0B, 16'h0000, 2);
      acc2(1, 5'h0A, 16'h0002, 2);
      acc2(0, 5'h10, 16'h0000, 2);
      chk("mode byte", q, s ? 16'h0042 : 16'h0057);
    end
    for (int t = 0; t < 2; t++) begin
      n = 1 + ($random(seed) & 7);
      repeat (n) begin
        @(posedge clk_sys);
        ev <= t ? 2'b10 : 2'b01;
        @(posedge clk_sys);
        ev <= 2'b00;
      end
      acc2(1, 5'h03, 16'h0011, 0);
      acc2(0, t ? 5'h0F : 5'h0E, 16'h0000, 2);
      chk("tally refused", q, 16'h0000);
      acc2(0, t ? 5'h0F : 5'h0E, 16'h0000, 2);
      chk("tally", q, 16'(n));
      acc2(0, t ? 5'h0F : 5'h0E, 16'h0000, 2);
      chk("tally cleared", q, 16'h0000);
    end
    end_of_test();
  end
endmodule : host_port_remote_read_pacing_bench
